// ==== uec_defs.vh ====
// register map, field positions, reset values and axi response codes for the usb error enable/config bank
`ifndef UEC_DEFS_VH
`define UEC_DEFS_VH

// offsets of the two banks and the status word, then the clear/set/invert alias codes
`define UEC_EIE_BASE     8'h00
`define UEC_CFG_BASE     8'h10
`define UEC_STAT_BASE    8'h20
`define UEC_ALIAS_CLR    2'h1
`define UEC_ALIAS_SET    2'h2
`define UEC_ALIAS_INV    2'h3

// error enable field positions
`define UEC_EIE_PID      0
`define UEC_EIE_CRC5_EOF 1
`define UEC_EIE_CRC16    2
`define UEC_EIE_DFN      3
`define UEC_EIE_BTO      4
`define UEC_EIE_DMA      5
`define UEC_EIE_BMX      6
`define UEC_EIE_BTS      7

// configuration field positions
`define UEC_CFG_ASUSP    0
`define UEC_CFG_SIDL     4
`define UEC_CFG_OEMON    6
`define UEC_CFG_EYE      7
`define UEC_CFG_MASK     8'hD1

// reset values
`define UEC_EIE_RST      8'h00
`define UEC_CFG_RST      8'h00

// axi response codes
`define UEC_RESP_OKAY    2'h0
`define UEC_RESP_SLVERR  2'h2

`endif

// ==== uec_regs.v ====
// usb error interrupt enable and configuration register bank with axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "uec_defs.vh"

// Overview of operation
// - bits 31 to 8 of both registers are not built and read back as zero.
// - enable bit 7 passes the bit-stuffing error flag to the error interrupt.
// - enable bit 6 passes the bus matrix error flag.
// - enable bit 5 passes the dma error flag.
// - enable bit 4 passes the bus turnaround time-out flag.
// - enable bit 3 passes the data field size error flag.
// - enable bit 2 passes the sixteen-bit crc failure flag.
// - in device mode enable bit 1 passes the five-bit crc error flag.
// - in host mode enable bit 1 passes the end-of-frame error flag instead.
// - enable bit 0 passes the packet identifier check failure flag.
// - an enabled error reaches the usb interrupt request only with the master error enable set.
// - configuration bit 7 turns the transceiver eye-pattern test on.
// - configuration bit 6 lets the active-low drive monitor follow the line drive intervals.
// - configuration bit 4 stops the module while the device is in idle.
// - clear, set and invert aliases sit at 0x4, 0x8 and 0xC above each register.
// - configuration bit 0 suspends the module automatically on sleep, else only software does.
module uec_regs (
  input  wire        clk_sys,
  input  wire        rstn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // error flags from the protocol engine, same clock
  input  wire [7:0]  err_flags,
  input  wire        host_mode,
  input  wire        error_irq_master_en,
  // line drive from the transceiver, asynchronous pin
  input  wire        line_drive,
  // power state inputs, asynchronous pins
  input  wire        idle_mode,
  input  wire        sleep_mode,
  input  wire        software_suspend,
  // outputs to the usb core
  output reg         usb_irq_request,
  output reg         eye_pattern_test_en,
  output reg         drive_monitor_n,
  output reg         module_stopped,
  output reg         module_suspend
);

  // register storage, low byte only
  reg  [7:0]  eie_q;
  reg  [7:0]  eie_d;
  reg  [7:0]  cfg_q;
  reg  [7:0]  cfg_d;

  // pending write channel captures
  reg  [7:0]  awaddr_q;
  reg         aw_have_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         w_have_q;

  // synchronised pins
  wire [3:0]  pins_sync;
  wire        drive_s;
  wire        idle_s;
  wire        sleep_s;
  wire        swsusp_s;

  // gated error sources, write decode and read mux
  wire [7:0]  err_gated;
  wire        err_any;
  wire        wr_fire;
  wire [1:0]  wr_alias;
  wire        wr_hit_eie;
  wire        wr_hit_cfg;
  wire [7:0]  wr_byte;
  reg  [7:0]  rd_val;
  reg         rd_ok;

  uec_sync3 #(
    .WIDTH (4)
  ) i_uec_sync3 (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .din     ({software_suspend, sleep_mode, idle_mode, line_drive}),
    .dout    (pins_sync)
  );

  assign drive_s  = pins_sync[0];
  assign idle_s   = pins_sync[1];
  assign sleep_s  = pins_sync[2];
  assign swsusp_s = pins_sync[3];

  // each enable bit passes its own flag; bit 1 flag is chosen by mode upstream,
  // so host_mode is only reported in the status word
  assign err_gated = err_flags & eie_q;
  // the remaining causes follow the same mask
  // bit 1 carries crc5 in device mode and eof in host mode
  assign err_any   = |err_gated;

  // write decode: word address and alias in the two low word bits
  assign wr_fire    = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_alias   = awaddr_q[3:2];
  assign wr_hit_eie = ({awaddr_q[7:4], 4'h0} == `UEC_EIE_BASE);
  assign wr_hit_cfg = ({awaddr_q[7:4], 4'h0} == `UEC_CFG_BASE);
  assign wr_byte    = wdata_q[7:0] & {8{wstrb_q[0]}};

  // next-value logic with clear/set/invert aliases
  always @* begin
    eie_d = eie_q;
    cfg_d = cfg_q;
    if (wr_fire && wr_hit_eie) begin
      case (wr_alias)
        2'h0:             eie_d = wstrb_q[0] ? wdata_q[7:0] : eie_q;
        `UEC_ALIAS_CLR:   eie_d = eie_q & ~wr_byte;
        `UEC_ALIAS_SET:   eie_d = eie_q | wr_byte;
        `UEC_ALIAS_INV:   eie_d = eie_q ^ wr_byte;
        default:          eie_d = eie_q;
      endcase
    end
    if (wr_fire && wr_hit_cfg) begin
      case (wr_alias)
        2'h0:             cfg_d = wstrb_q[0] ? wdata_q[7:0] : cfg_q;
        `UEC_ALIAS_CLR:   cfg_d = cfg_q & ~wr_byte;
        `UEC_ALIAS_SET:   cfg_d = cfg_q | wr_byte;
        `UEC_ALIAS_INV:   cfg_d = cfg_q ^ wr_byte;
        default:          cfg_d = cfg_q;
      endcase
      // unbuilt config bits never hold a one
      cfg_d = cfg_d & `UEC_CFG_MASK;
    end
  end

  // registers clear at reset; the enable register is fully read/write, config only in bits 7, 6, 4 and 0
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      eie_q <= `UEC_EIE_RST;
      cfg_q <= `UEC_CFG_RST;
    end else begin
      eie_q <= eie_d;
      cfg_q <= cfg_d;
    end
  end

  // write channels: address and data taken in either order, one write in flight
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UEC_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_have_q && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      // response once both halves are held; unmapped words answer slverr
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit_eie || wr_hit_cfg) ? `UEC_RESP_OKAY : `UEC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode; aliases read back the base value, status word shows live state
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 8'h00;
    case (s_axi_araddr[7:4])
      4'h0:    rd_val = eie_q;
      4'h1:    rd_val = cfg_q;
      4'h2:    rd_val = {2'h0, host_mode, module_suspend, module_stopped, usb_irq_request,
                         err_any, drive_s};
      default: rd_ok  = 1'b0;
    endcase
  end

  // read channel: one read in flight, answer two edges after valid
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `UEC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_val};
        s_axi_rresp  <= rd_ok ? `UEC_RESP_OKAY : `UEC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // core-facing outputs, all registered
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      usb_irq_request     <= 1'b0;
      eye_pattern_test_en <= 1'b0;
      drive_monitor_n     <= 1'b1;
      module_stopped      <= 1'b0;
      module_suspend      <= 1'b0;
    end else begin
      usb_irq_request     <= err_any & error_irq_master_en;
      eye_pattern_test_en <= cfg_q[`UEC_CFG_EYE];
      // low while the lines are driven, held high when monitoring is off
      drive_monitor_n     <= ~(cfg_q[`UEC_CFG_OEMON] & drive_s);
      module_stopped      <= cfg_q[`UEC_CFG_SIDL] & idle_s;
      // software suspend always works; sleep adds to it only when enabled
      module_suspend      <= swsusp_s | (cfg_q[`UEC_CFG_ASUSP] & sleep_s);
    end
  end

endmodule // uec_regs

`default_nettype wire

// ==== uec_regs_checker.sv ====
// port-level assertions for the usb error enable and configuration bank
`timescale 1ns/10ps
`default_nettype none
module uec_regs_checker (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  err_flags,
  input wire logic        error_irq_master_en,
  input wire logic        line_drive,
  input wire logic        idle_mode,
  input wire logic        software_suspend,
  input wire logic        usb_irq_request,
  input wire logic        drive_monitor_n,
  input wire logic        module_stopped,
  input wire logic        module_suspend
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // six cycles covers the pin synchroniser plus the output stage
  sequence s_sw_held; software_suspend [*6]; endsequence
  sequence s_awake; !idle_mode [*6]; endsequence
  sequence s_quiet; !line_drive [*6]; endsequence
  sequence s_no_cause; err_flags == 8'h00 || !error_irq_master_en; endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_RDATA_TOP: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  AST_IRQ_GATE: assert property (s_no_cause |=> !usb_irq_request)
    else $error("irq without enabled cause");
  AST_SUSP_SW: assert property (s_sw_held |-> module_suspend)
    else $error("software suspend ignored");
  AST_STOP_AWAKE: assert property (s_awake |-> !module_stopped)
    else $error("stopped outside idle");
  AST_MON_QUIET: assert property (s_quiet |-> drive_monitor_n)
    else $error("monitor active with line quiet");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_wr_both |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken while response pending");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule // uec_regs_checker
bind uec_regs uec_regs_checker i_uec_regs_checker (.clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .err_flags, .error_irq_master_en, .line_drive, .idle_mode, .software_suspend,
  .usb_irq_request, .drive_monitor_n, .module_stopped, .module_suspend);
`default_nettype wire

// ==== uec_sync3.v ====
// three-flop input synchroniser with second/third agreement filter
`timescale 1ns/10ps
`default_nettype none

module uec_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // first flop feeds only the second; a change counts when stages two and three agree
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (s2_q & s3_q) | (dout & (s2_q | s3_q));
    end
  end

endmodule // uec_sync3

`default_nettype wire

// ==== usb_error_irq_enable_and_config_test.sv ====
// self-checking bench for the usb error enable and configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "uec_defs.vh"
module usb_error_irq_enable_and_config_test;
  logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, host_mode, error_irq_master_en, line_drive, idle_mode;
  logic        sleep_mode, software_suspend, usb_irq_request, eye_pattern_test_en;
  logic        drive_monitor_n, module_stopped, module_suspend;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, err_flags;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          err_total = 0, num_checks = 0, cyc = 0;
  logic [3:0]  pin_outs;
  // core-facing outputs packed as eye, monitor_n, stopped, suspend
  assign pin_outs = {eye_pattern_test_en, drive_monitor_n, module_stopped, module_suspend};
  uec_regs i_uec_regs (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .err_flags, .host_mode, .error_irq_master_en, .line_drive,
    .idle_mode, .sleep_mode, .software_suspend, .usb_irq_request, .eye_pattern_test_en,
    .drive_monitor_n, .module_stopped, .module_suspend);
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clk_sys);
  endtask
  // write one place, read another back and compare
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [7:0] ra,
                      input logic [31:0] e);
    logic [1:0]  r;
    logic [31:0] q;
    if (a != 8'hFF) begin
      wr(a, d, r);
      chk(r, `UEC_RESP_OKAY);
    end
    rd(ra, q, r);
    chk(r, `UEC_RESP_OKAY);
    chk(q, e);
  endtask
  task automatic t_regs;
    logic [1:0]  r;
    logic [31:0] q;
    wchk(8'hFF, 32'h0, 8'h00, 32'h0);
    wchk(8'hFF, 32'h0, 8'h10, 32'h0);
    wchk(8'h00, 32'hFFFFFFFF, 8'h00, 32'hFF);
    wchk(8'h04, 32'h0F, 8'h00, 32'hF0);
    wchk(8'h08, 32'h03, 8'h00, 32'hF3);
    wchk(8'h0C, 32'hFF, 8'h00, 32'h0C);
    wchk(8'h10, 32'hFFFFFFFF, 8'h10, 32'hD1);
    wchk(8'h1C, 32'hFF, 8'h10, 32'h0);
    wr(8'h30, 32'hFF, r);
    chk(r, `UEC_RESP_SLVERR);
    // an unmapped read answers an error and an all-zero word
    rd(8'h30, q, r);
    chk(r, `UEC_RESP_SLVERR);
    chk(q, 32'h0);
  endtask
  // each cause alone, then the master enable cut; last pass runs in host mode
  task automatic t_irq;
    logic [1:0] r;
    int         b;
    error_irq_master_en <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      b = (i == 8) ? 1 : i;
      host_mode <= (i == 8);
      wr(8'h00, 32'h1 << b, r);
      err_flags <= 8'h01 << b;
      wt(2);
      chk(usb_irq_request, 32'h1);
      err_flags <= ~(8'h01 << b);
      wt(2);
      chk(usb_irq_request, 32'h0);
    end
    err_flags <= 8'h02;
    error_irq_master_en <= 1'h0;
    wt(2);
    chk(usb_irq_request, 32'h0);
  endtask
  // outputs packed as eye, monitor_n, stopped, suspend
  task automatic t_pins;
    logic [1:0] r;
    {line_drive, idle_mode, sleep_mode} <= 3'h7;
    wr(8'h10, 32'hD1, r);
    wt(6);
    chk(pin_outs, 32'hB);
    // quiet line and awake device must release monitor and stop
    {line_drive, idle_mode} <= 2'h0;
    wt(6);
    chk(pin_outs, 32'hD);
    // sleep alone must not suspend once automatic suspend is off
    wr(8'h10, 32'h0, r);
    wt(6);
    chk(pin_outs, 32'h4);
    {line_drive, idle_mode} <= 2'h3;
    software_suspend <= 1'h1;
    wt(6);
    chk(pin_outs, 32'h5);
    // give the checker a few edges to judge the held suspend
    wt(2);
  endtask
  // hang guard: the sequence needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, err_flags} = 56'h0;
    {host_mode, error_irq_master_en, line_drive, idle_mode, sleep_mode, software_suspend} = 6'h00;
    s_axi_wstrb = 4'hF;
    wt(20);
    rstn <= 1'h1;
    t_regs;
    t_irq;
    t_pins;
    final_report;
  end
endmodule // usb_error_irq_enable_and_config_test
`default_nettype wire
